// file: rtl/flash_iap_map.vh
/*
 * Register offsets, field positions, reset values, codes and timing for the
 * in-application flash programming controller.
 * Assumes an 8-bit CPU data-memory port on the system clock.
 */
// Behaviour
// - write_enabled_flag is set only by hardware on unlock; software may only clear it
// - operation_select: 000 write, 001 erase, 011 read, 110 unlock; rest reserved
// - Erase is a 256-word block on smallest variant, else 32 or 64-word page
// - unlock_launch with operation_select 110 starts the write-enable procedure
// - write_go starts a flash write; hardware clears it on completion
// - read_go starts a one-word flash read; hardware clears it on completion
// - read_enable_bit high permits flash reads, low blocks them
// - Writing 55H to chip_reset_key resets the whole chip
// - buffer_clear_go starts write-buffer clear on variants other than 0; hardware clears it when done
// - Flash word address is high register bits above the low register byte
// - Unimplemented upper bits of address-high and buffer control read zero
// - Data word 0 holds the 16-bit flash word, low byte then high byte
// - Unlock pattern 00,04,0D,09,C3,40 into data words 1-3 within 300 us; the timer allows 9 sub-clock ticks, about 275 us
// - Timeout or wrong pattern leaves writing disabled; correct one sets the flag
// - CPU is halted while write_go or read_go is high
`ifndef FLASH_IAP_MAP_VH
`define FLASH_IAP_MAP_VH

// ==========================================================================
// Register offsets in the data-memory window
`define OFS_CTRL_MAIN 8'h67
`define OFS_RESET_KEY 8'h68
`define OFS_BUF_CTRL 8'h69
`define OFS_ADDR_LOW 8'h6A
`define OFS_ADDR_HIGH 8'h6B
`define OFS_DATA_BASE 8'h6C
`define OFS_DATA_LAST 8'h73

// ==========================================================================
// Control register fields
`define BIT_WEN_FLAG 7
`define BIT_OP_HI 6
`define BIT_OP_LO 4
`define BIT_UNLOCK 3
`define BIT_WRITE_GO 2
`define BIT_READ_EN 1
`define BIT_READ_GO 0
`define BIT_BUF_CLR 0
`define CTRL_MAIN_RESET 8'h70
`define OP_RESET 3'h7

// ==========================================================================
// Operation codes
`define OP_WRITE 3'h0
`define OP_ERASE 3'h1
`define OP_READ 3'h3
`define OP_UNLOCK 3'h6

// Flash port commands
`define CMD_WRITE 2'h0
`define CMD_ERASE 2'h1
`define CMD_READ 2'h2
`define CMD_BUFCLR 2'h3

// ==========================================================================
// Keys and unlock pattern
`define CHIP_RESET_KEY 8'h55
`define PAT0 8'h00
`define PAT1 8'h04
`define PAT2 8'h0D
`define PAT3 8'h09
`define PAT4 8'hC3
`define PAT5 8'h40
`define PAT_LAST 3'h5
`define PAT_FIRST_IDX 3'h2

// ==========================================================================
// Timing
`define CLK_HZ 200000000
`define SUB_CLK_HZ 32768
`define UNLOCK_TIMEOUT_US 300
`define SUB_DIV_CYCLES (`CLK_HZ / `SUB_CLK_HZ)
`define UNLOCK_SUB_TICKS ((`UNLOCK_TIMEOUT_US * `SUB_CLK_HZ) / 1000000)

`endif

// file: rtl/unlock_timer.v
/*
 * Unlock window timer: derives a sub-clock enable from the system clock and
 * counts sub-clock ticks until the window overflows.
 * Assumes start and stop are single-cycle pulses on the same clock.
 */
module unlock_timer #(
    parameter SUB_DIV = 6103,
    parameter TICKS = 9
) (
    input wire clk_i,
    input wire rst_i,
    input wire start_i,
    input wire stop_i,
    output reg expired_o
);

// ==========================================================================
// Sub-clock divider and tick counter
reg [15:0] div_reg;
reg [7:0] tick_reg;
reg run_reg;
wire sub_tick;

assign sub_tick = run_reg && (div_reg == SUB_DIV[15:0] - 16'h0001);

always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
        div_reg <= 16'h0000;
        tick_reg <= 8'h00;
        run_reg <= 1'b0;
        expired_o <= 1'b0;
    end else begin
        expired_o <= 1'b0;
        if (start_i) begin
            // Restart wins so a fresh attempt always gets the full window
            div_reg <= 16'h0000;
            tick_reg <= 8'h00;
            run_reg <= 1'b1;
        end else if (stop_i) begin
            run_reg <= 1'b0;
        end else if (run_reg) begin
            div_reg <= sub_tick ? 16'h0000 : div_reg + 16'h0001;
            if (sub_tick) begin
                tick_reg <= tick_reg + 8'h01;
                if (tick_reg == TICKS[7:0] - 8'h01) begin
                    run_reg <= 1'b0;
                    expired_o <= 1'b1;
                end
            end
        end
    end
end

endmodule // unlock_timer

// file: rtl/flash_iap_control.v
/*
 * In-application flash programming controller: control, key, buffer,
 * address and data registers, unlock procedure and flash command sequencing.
 * Assumes the CPU register port and the flash array run on clk_i, and the
 * flash array answers each request with a one-cycle done pulse.
 */
`include "flash_iap_map.vh"

module flash_iap_control #(
    parameter VARIANT = 0,
    parameter SUB_DIV = `SUB_DIV_CYCLES,
    parameter UNLOCK_TICKS = `UNLOCK_SUB_TICKS
) (
    input wire clk_i,
    input wire rst_i,
    input wire [7:0] reg_addr_i,
    input wire reg_wr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_rd_i,
    output reg [7:0] reg_rdata_o,
    output reg flash_req_o,
    output reg [1:0] flash_cmd_o,
    output reg [13:0] flash_addr_o,
    output reg [63:0] flash_wdata_o,
    input wire [15:0] flash_rdata_i,
    input wire flash_done_i,
    output reg cpu_halt_o,
    output reg chip_reset_o,
    output reg write_enabled_o
);

localparam ST_IDLE = 2'd0;
localparam ST_UNLOCK = 2'd1;
localparam ST_BUSY = 2'd2;

// ==========================================================================
// Helper functions
function [5:0] high_mask;
    input integer v;
    begin
        case (v)
            0: high_mask = 6'h0F;
            1: high_mask = 6'h1F;
            default: high_mask = 6'h3F;
        endcase
    end
endfunction

function [7:0] pattern_byte;
    input [2:0] seq;
    begin
        case (seq)
            3'h0: pattern_byte = `PAT0;
            3'h1: pattern_byte = `PAT1;
            3'h2: pattern_byte = `PAT2;
            3'h3: pattern_byte = `PAT3;
            3'h4: pattern_byte = `PAT4;
            default: pattern_byte = `PAT5;
        endcase
    end
endfunction

// Block or page base: low word bits are don't-care for erase
function [13:0] erase_base;
    input [13:0] a;
    input integer v;
    begin
        case (v)
            0: erase_base = {a[13:8], 8'h00};
            1: erase_base = {a[13:5], 5'h00};
            default: erase_base = {a[13:6], 6'h00};
        endcase
    end
endfunction

// ==========================================================================
// Register storage
reg wen_flag_reg;
reg [2:0] op_reg;
reg unlock_reg;
reg write_go_reg;
reg read_en_reg;
reg read_go_reg;
reg buf_clr_reg;
reg [6:0] key_reg;
reg [7:0] addr_low_reg;
reg [5:0] addr_high_reg;
reg [7:0] data_reg [0:7];
reg [1:0] state_reg;
reg [1:0] cmd_reg;
reg [2:0] seq_reg;
integer i;

wire wr_ctrl = reg_wr_i && (reg_addr_i == `OFS_CTRL_MAIN);
wire wr_key = reg_wr_i && (reg_addr_i == `OFS_RESET_KEY);
wire wr_buf = reg_wr_i && (reg_addr_i == `OFS_BUF_CTRL) && (VARIANT != 0);
wire wr_alo = reg_wr_i && (reg_addr_i == `OFS_ADDR_LOW);
wire wr_ahi = reg_wr_i && (reg_addr_i == `OFS_ADDR_HIGH);
wire wr_data = reg_wr_i && (reg_addr_i >= `OFS_DATA_BASE) && (reg_addr_i <= `OFS_DATA_LAST);
wire [7:0] data_ofs = reg_addr_i - `OFS_DATA_BASE;
wire [2:0] data_idx = data_ofs[2:0];

wire [13:0] word_addr = {addr_high_reg & high_mask(VARIANT), addr_low_reg};

// ==========================================================================
// Request arbitration in idle
wire idle = (state_reg == ST_IDLE);
wire op_is_prog = (op_reg == `OP_WRITE) || (op_reg == `OP_ERASE);
wire bufclr_start = idle && buf_clr_reg;
wire write_req = idle && write_go_reg && !buf_clr_reg;
wire write_start = write_req && op_is_prog && wen_flag_reg;
wire write_reject = write_req && !(op_is_prog && wen_flag_reg);
wire read_req = idle && read_go_reg && !write_go_reg && !buf_clr_reg;
wire read_start = read_req && (op_reg == `OP_READ) && read_en_reg;
wire read_reject = read_req && !((op_reg == `OP_READ) && read_en_reg);
wire unlock_start = idle && unlock_reg && (op_reg == `OP_UNLOCK) &&
    !buf_clr_reg && !write_go_reg && !read_go_reg;
wire done_now = (state_reg == ST_BUSY) && flash_done_i;

// ==========================================================================
// Unlock pattern tracking
wire in_unlock = (state_reg == ST_UNLOCK);
wire timer_expired;
wire pat_write = in_unlock && wr_data && (data_idx >= `PAT_FIRST_IDX);
wire pat_hit = pat_write && (data_idx == seq_reg + `PAT_FIRST_IDX) &&
    (reg_wdata_i == pattern_byte(seq_reg));
wire unlock_ok = pat_hit && (seq_reg == `PAT_LAST) && !timer_expired;
wire unlock_fail = in_unlock && (timer_expired || (pat_write && !pat_hit));

unlock_timer #(
    .SUB_DIV(SUB_DIV),
    .TICKS(UNLOCK_TICKS)
) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(unlock_start),
    .stop_i(unlock_ok || unlock_fail),
    .expired_o(timer_expired)
);

// ==========================================================================
// Next values of the hardware-cleared and hardware-set bits
wire clr_write = write_reject || (done_now && (cmd_reg == `CMD_WRITE || cmd_reg == `CMD_ERASE));
wire clr_read = read_reject || (done_now && (cmd_reg == `CMD_READ));
wire clr_buf = done_now && (cmd_reg == `CMD_BUFCLR);
// Software write of one to a go bit beats the hardware clear in the same cycle
wire write_go_next = (write_go_reg && !clr_write) || (wr_ctrl && reg_wdata_i[`BIT_WRITE_GO]);
wire read_go_next = (read_go_reg && !clr_read) || (wr_ctrl && reg_wdata_i[`BIT_READ_GO]);
// Hardware set wins over a software clear in the same cycle
wire wen_next = unlock_ok ||
    (wen_flag_reg && !(wr_ctrl && !reg_wdata_i[`BIT_WEN_FLAG]));

// ==========================================================================
// Control and data registers
always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
        wen_flag_reg <= 1'b0;
        op_reg <= `OP_RESET;
        unlock_reg <= 1'b0;
        write_go_reg <= 1'b0;
        read_en_reg <= 1'b0;
        read_go_reg <= 1'b0;
        buf_clr_reg <= 1'b0;
        key_reg <= 7'h00;
        addr_low_reg <= 8'h00;
        addr_high_reg <= 6'h00;
        for (i = 0; i < 8; i = i + 1) begin
            data_reg[i] <= 8'h00;
        end
        cpu_halt_o <= 1'b0;
        chip_reset_o <= 1'b0;
        write_enabled_o <= 1'b0;
    end else begin
        wen_flag_reg <= wen_next;
        write_enabled_o <= wen_next;
        write_go_reg <= write_go_next;
        read_go_reg <= read_go_next;
        cpu_halt_o <= write_go_next || read_go_next;
        chip_reset_o <= wr_key && (reg_wdata_i == `CHIP_RESET_KEY);
        if (wr_ctrl) begin
            op_reg <= reg_wdata_i[`BIT_OP_HI:`BIT_OP_LO];
            read_en_reg <= reg_wdata_i[`BIT_READ_EN];
        end
        // Launch bit is consumed by each attempt so a stale one cannot relaunch
        if (wr_ctrl) begin
            unlock_reg <= reg_wdata_i[`BIT_UNLOCK];
        end else if (unlock_ok || unlock_fail) begin
            unlock_reg <= 1'b0;
        end
        if (wr_buf && reg_wdata_i[`BIT_BUF_CLR]) begin
            buf_clr_reg <= 1'b1;
        end else if (clr_buf) begin
            buf_clr_reg <= 1'b0;
        end
        if (wr_key) begin
            key_reg <= reg_wdata_i[6:0];
        end
        if (wr_alo) begin
            addr_low_reg <= reg_wdata_i;
        end
        if (wr_ahi) begin
            addr_high_reg <= reg_wdata_i[5:0] & high_mask(VARIANT);
        end
        // CPU is halted during a read, so the flash result cannot collide
        if (done_now && (cmd_reg == `CMD_READ)) begin
            data_reg[0] <= flash_rdata_i[7:0];
            data_reg[1] <= flash_rdata_i[15:8];
        end else if (wr_data) begin
            data_reg[data_idx] <= reg_wdata_i;
        end
    end
end

// ==========================================================================
// Sequencer
always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
        state_reg <= ST_IDLE;
        cmd_reg <= `CMD_WRITE;
        seq_reg <= 3'h0;
        flash_req_o <= 1'b0;
        flash_cmd_o <= `CMD_WRITE;
        flash_addr_o <= 14'h0000;
        flash_wdata_o <= 64'h0000000000000000;
    end else begin
        flash_req_o <= 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (bufclr_start) begin
                    cmd_reg <= `CMD_BUFCLR;
                    flash_cmd_o <= `CMD_BUFCLR;
                    flash_req_o <= 1'b1;
                    state_reg <= ST_BUSY;
                end else if (write_start) begin
                    cmd_reg <= (op_reg == `OP_ERASE) ? `CMD_ERASE : `CMD_WRITE;
                    flash_cmd_o <= (op_reg == `OP_ERASE) ? `CMD_ERASE : `CMD_WRITE;
                    flash_addr_o <= (op_reg == `OP_ERASE) ?
                        erase_base(word_addr, VARIANT) : word_addr;
                    flash_wdata_o <= {data_reg[7], data_reg[6], data_reg[5], data_reg[4],
                        data_reg[3], data_reg[2], data_reg[1], data_reg[0]};
                    flash_req_o <= 1'b1;
                    state_reg <= ST_BUSY;
                end else if (read_start) begin
                    cmd_reg <= `CMD_READ;
                    flash_cmd_o <= `CMD_READ;
                    flash_addr_o <= word_addr;
                    flash_req_o <= 1'b1;
                    state_reg <= ST_BUSY;
                end else if (unlock_start) begin
                    seq_reg <= 3'h0;
                    state_reg <= ST_UNLOCK;
                end
            end
            ST_UNLOCK: begin
                if (unlock_ok || unlock_fail) begin
                    state_reg <= ST_IDLE;
                end else if (pat_hit) begin
                    seq_reg <= seq_reg + 3'h1;
                end
            end
            ST_BUSY: begin
                if (flash_done_i) begin
                    state_reg <= ST_IDLE;
                end
            end
            default: begin
                state_reg <= ST_IDLE;
            end
        endcase
    end
end

// ==========================================================================
// Read data, one cycle after the read strobe
reg [7:0] rd_mux;

always @* begin
    rd_mux = 8'h00;
    case (reg_addr_i)
        `OFS_CTRL_MAIN: rd_mux = {wen_flag_reg, op_reg, unlock_reg, write_go_reg,
            read_en_reg, read_go_reg};
        `OFS_RESET_KEY: rd_mux = {1'b0, key_reg};
        `OFS_BUF_CTRL: rd_mux = {7'h00, buf_clr_reg};
        `OFS_ADDR_LOW: rd_mux = addr_low_reg;
        `OFS_ADDR_HIGH: rd_mux = {2'h0, addr_high_reg};
        default: begin
            if (reg_addr_i >= `OFS_DATA_BASE && reg_addr_i <= `OFS_DATA_LAST) begin
                rd_mux = data_reg[data_idx];
            end
        end
    endcase
end

always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
        reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
        reg_rdata_o <= rd_mux;
    end
end

endmodule // flash_iap_control

// file: verif/flash_iap_sva.sv
/*
 * Port-level assertions for the flash programming controller.
 * Assumes flash_iap_map.vh is on the include path and one clock domain.
 */
`include "flash_iap_map.vh"

module flash_iap_sva #(
    parameter VARIANT = 0,
    parameter SUB_DIV = 6103,
    parameter UNLOCK_TICKS = 9
) (
    input wire clk_i,
    input wire rst_i,
    input wire [7:0] reg_addr_i,
    input wire reg_wr_i,
    input wire [7:0] reg_wdata_i,
    input wire flash_req_o,
    input wire [1:0] flash_cmd_o,
    input wire [13:0] flash_addr_o,
    input wire flash_done_i,
    input wire cpu_halt_o,
    input wire chip_reset_o,
    input wire write_enabled_o
);
    // Low address bits that an erase ignores, per variant
    localparam logic [13:0] ALIGN = (VARIANT == 0) ? 14'h00FF : (VARIANT == 1) ? 14'h001F : 14'h003F;
    logic key_q;
    logic key_wr;

    assign key_wr = reg_wr_i && reg_addr_i == `OFS_RESET_KEY && reg_wdata_i == `CHIP_RESET_KEY;

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            key_q <= 1'b0;
        end else begin
            key_q <= key_wr;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ======================================================================
    // Erase launch steps
    sequence s_erase_go;
        reg_wr_i && reg_addr_i == `OFS_CTRL_MAIN && reg_wdata_i == 8'h94 && write_enabled_o && !cpu_halt_o;
    endsequence
    sequence s_erase_req;
        cpu_halt_o ##1 (flash_req_o && flash_cmd_o == `CMD_ERASE);
    endsequence

    // ======================================================================
    // Properties
    AST_ERASE_START: assert property (s_erase_go |=> s_erase_req)
        else $error("erase launch did not reach the flash port");
    AST_REQ_PULSE: assert property (flash_req_o |=> !flash_req_o)
        else $error("flash request longer than one cycle");
    AST_PORT_HOLD: assert property (!flash_req_o |-> $stable(flash_cmd_o) && $stable(flash_addr_o))
        else $error("flash command or address moved without a request");
    AST_WRITE_GATE: assert property (flash_req_o && flash_cmd_o inside {`CMD_WRITE, `CMD_ERASE}
        |-> write_enabled_o)
        else $error("write or erase issued while writing disabled");
    AST_ERASE_ALIGN: assert property (flash_req_o && flash_cmd_o == `CMD_ERASE
        |-> (flash_addr_o & ALIGN) == 14'h0000)
        else $error("erase address not aligned to erase unit");
    AST_HALT_REQ: assert property (flash_req_o && flash_cmd_o != `CMD_BUFCLR |-> cpu_halt_o)
        else $error("CPU not halted during flash access");
    AST_HALT_END: assert property (cpu_halt_o && flash_done_i && flash_cmd_o != `CMD_BUFCLR
        |=> !cpu_halt_o)
        else $error("halt did not end at flash completion");
    AST_KEY_RESET: assert property (key_wr |=> chip_reset_o ##1 !chip_reset_o)
        else $error("key write did not give one reset pulse");
    AST_RESET_CAUSE: assert property (chip_reset_o |-> key_q)
        else $error("chip reset without key write");
    AST_FLAG_SET: assert property ($rose(write_enabled_o) |-> $past(reg_wr_i)
        && $past(reg_addr_i) == `OFS_DATA_LAST && $past(reg_wdata_i) == `PAT5)
        else $error("write enable rose without final pattern byte");
    AST_FLAG_CLEAR: assert property (reg_wr_i && reg_addr_i == `OFS_CTRL_MAIN
        && !reg_wdata_i[`BIT_WEN_FLAG] |=> !write_enabled_o)
        else $error("software clear of write enable ignored");
endmodule // flash_iap_sva

bind flash_iap_control flash_iap_sva #(.VARIANT(VARIANT), .SUB_DIV(SUB_DIV),
    .UNLOCK_TICKS(UNLOCK_TICKS)) u_sva (.clk_i(clk_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
    .flash_req_o(flash_req_o), .flash_cmd_o(flash_cmd_o), .flash_addr_o(flash_addr_o),
    .flash_done_i(flash_done_i), .cpu_halt_o(cpu_halt_o), .chip_reset_o(chip_reset_o),
    .write_enabled_o(write_enabled_o));

// file: verif/flash_array_model.sv
/*
 * Behavioural flash array: answers each request after lat_i cycles.
 * Assumes one-cycle requests on the controller clock.
 */
module flash_array_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req_i,
    input wire logic [13:0] addr_i,
    input wire logic [7:0] lat_i,
    output logic done_o,
    output logic [15:0] rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt;

    // ======================================================================
    // Answer; read bus toggles outside the done cycle so stale data is never valid
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt <= 8'h00;
            done_o <= 1'b0;
            rdata_o <= 16'h0000;
        end else begin
            done_o <= 1'b0;
            rdata_o <= ~rdata_o;
            if (req_i) begin
                cnt <= lat_i;
            end else if (cnt != 8'h00) begin
                cnt <= cnt - 8'h01;
                if (cnt == 8'h01) begin
                    done_o <= 1'b1;
                    rdata_o <= {2'h2, addr_i} ^ 16'h5A00;
                end
            end
        end
    end
endmodule // flash_array_model

// file: verif/flash_iap_control_tb.sv
/*
 * Register-level testbench for the flash programming controller.
 * Assumes VARIANT 1 (page erase, five high address bits) and a short unlock window.
 */
module flash_iap_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i;
    logic rst_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_rd_i = 1'b0;
    wire [7:0] reg_rdata_o;
    wire flash_req_o;
    wire [1:0] flash_cmd_o;
    wire [13:0] flash_addr_o;
    wire [63:0] flash_wdata_o;
    wire [15:0] flash_rdata_i;
    wire flash_done_i;
    wire cpu_halt_o;
    wire chip_reset_o;
    wire write_enabled_o;
    logic [7:0] lat = 8'h01;
    logic [7:0] pats [0:5] = '{8'h00, 8'h04, 8'h0D, 8'h09, 8'hC3, 8'h40};
    int err_total = 0;
    int tests_run = 0;
    int req_n = 0;
    int rst_seen = 0;
    logic [1:0] last_cmd;
    logic [13:0] last_addr;
    logic [63:0] last_wdata;
    logic [7:0] v;

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // Window of 8 x 3 clocks keeps a back-to-back pattern inside it
    flash_iap_control #(.VARIANT(1), .SUB_DIV(8), .UNLOCK_TICKS(3)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .flash_req_o(flash_req_o), .flash_cmd_o(flash_cmd_o), .flash_addr_o(flash_addr_o),
        .flash_wdata_o(flash_wdata_o), .flash_rdata_i(flash_rdata_i),
        .flash_done_i(flash_done_i), .cpu_halt_o(cpu_halt_o), .chip_reset_o(chip_reset_o),
        .write_enabled_o(write_enabled_o));

    flash_array_model u_flash (.clk_i(clk_i), .rst_i(rst_i), .req_i(flash_req_o),
        .addr_i(flash_addr_o), .lat_i(lat), .done_o(flash_done_i), .rdata_o(flash_rdata_i));

    // ======================================================================
    // Monitors
    always @(posedge clk_i) begin
        if (flash_req_o === 1'b1) begin
            req_n++;
            last_cmd = flash_cmd_o;
            last_addr = flash_addr_o;
            last_wdata = flash_wdata_o;
        end
        if (chip_reset_o === 1'b1) begin
            rst_seen++;
        end
    end

    // ======================================================================
    // Tasks
    task chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask

    task rchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        @(posedge clk_i);
        #1 v = reg_rdata_o;
        chk(v, exp);
    endtask

    task wait_idle;
        for (int k = 0; k < 100; k++) begin
            @(posedge clk_i);
            #1;
            if (cpu_halt_o === 1'b0) break;
        end
    endtask

    task pattern(input logic [7:0] p4);
        for (int i = 0; i < 6; i++) wr(8'h6E + 8'(i), (i == 4) ? p4 : pats[i]);
    endtask

    task report_and_stop;
        if (err_total == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        report_and_stop;
    end

    // ======================================================================
    // Sequence
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rchk(8'h67, 8'h70);
        for (int i = 8'h68; i <= 8'h73; i++) rchk(8'(i), 8'h00);
        rchk(8'h80, 8'h00);
        wr(8'h6B, 8'hFF);
        rchk(8'h6B, 8'h1F);
        wr(8'h68, 8'hAA);
        rchk(8'h68, 8'h2A);
        chk(rst_seen, 0);
        wr(8'h68, 8'h55);
        rchk(8'h68, 8'h55);
        chk(rst_seen, 1);
        wr(8'h67, 8'hE0);
        rchk(8'h67, 8'h60);
        wr(8'h67, 8'h14);
        wait_idle;
        rchk(8'h67, 8'h10);
        chk(req_n, 0);
        wr(8'h67, 8'h68);
        pattern(8'hC2);
        rchk(8'h67, 8'h60);
        wr(8'h67, 8'h68);
        repeat (60) @(posedge clk_i);
        pattern(8'hC3);
        rchk(8'h67, 8'h60);
        wr(8'h67, 8'h68);
        pattern(8'hC3);
        rchk(8'h67, 8'hE0);
        chk(write_enabled_o, 1);
        wr(8'h6A, 8'h7F);
        wr(8'h6B, 8'h03);
        wr(8'h67, 8'h94);
        wait_idle;
        chk(last_cmd, 1);
        chk(last_addr, 14'h0360);
        rchk(8'h67, 8'h90);
        wr(8'h69, 8'hFF);
        rchk(8'h69, 8'h01);
        rchk(8'h69, 8'h00);
        chk(last_cmd, 3);
        for (int i = 0; i < 8; i++) wr(8'h6C + 8'(i), 8'hA0 + 8'(i));
        lat = 8'd30;
        wr(8'h67, 8'h84);
        @(posedge clk_i);
        #1 chk(cpu_halt_o, 1);
        wait_idle;
        chk(last_cmd, 0);
        chk(last_wdata, 64'hA7A6A5A4A3A2A1A0);
        rchk(8'h67, 8'h80);
        lat = 8'd5;
        wr(8'h67, 8'hB1);
        wait_idle;
        chk(req_n, 3);
        rchk(8'h67, 8'hB0);
        wr(8'h67, 8'hB3);
        wait_idle;
        chk(last_addr, 14'h037F);
        rchk(8'h6C, 8'h7F);
        rchk(8'h6D, 8'hD9);
        rchk(8'h67, 8'hB2);
        wr(8'h67, 8'h30);
        rchk(8'h67, 8'h30);
        chk(write_enabled_o, 0);
        wr(8'h67, 8'h14);
        wait_idle;
        chk(req_n, 4);
        report_and_stop;
    end
endmodule // flash_iap_control_tb
